// *** dp_defs.svh ***
`ifndef DP_DEFS_SVH
`define DP_DEFS_SVH

`define DP_WIDTH      64
`define DP_GROUPS     4
`define DP_GRP_W      16
`define DP_BEATS      4
`define DP_BUF_DEPTH  2
`define DP_BURST_MAX  4
`define DP_ACT        1'h0
`define DP_IDLE       1'h1
`define DP_REF_NS     50
`define DP_BCLK_NS    400
`define DP_HALF_CYC   (`DP_BCLK_NS / (2 * `DP_REF_NS))
`define DP_SLOT_CPU   1'h0
`define DP_SLOT_CS    1'h1

`endif

// *** dp_pkg.sv ***
`include "dp_defs.svh"
package dp_pkg;
   typedef logic [`DP_WIDTH-1:0] word_t;
   typedef logic [`DP_GRP_W-1:0] grp_t;

   typedef struct packed {
      logic [`DP_WIDTH-1:0]  data;
      logic [`DP_GROUPS-1:0] flag;
      logic [`DP_GROUPS-1:0] pos;
      logic [`DP_GROUPS-1:0] neg;
      logic                  valid;
      logic                  busy;
   } link_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_SEND = 2'h1,
      ST_HOLD = 2'h3
   } tx_st_t;

   // Wire level is active low; inverted form is sent when cheaper
   function automatic logic [`DP_GRP_W:0] bus_encode(input grp_t prev,
                                                     input grp_t word);
      grp_t        nat;
      grp_t        diff;
      int unsigned cnt;
      nat  = ~word;
      diff = nat ^ prev;
      cnt  = 0;
      for (int i = 0; i < `DP_GRP_W; i++) begin
         cnt = cnt + int'(diff[i]);
      end
      if (cnt > `DP_GRP_W / 2) begin
         bus_encode = {`DP_ACT, word};
      end else begin
         bus_encode = {`DP_IDLE, nat};
      end
   endfunction

   function automatic grp_t bus_decode(input logic flag, input grp_t wv);
      bus_decode = (flag == `DP_ACT) ? wv : ~wv;
   endfunction
endpackage

// *** dp_bus_if.sv ***
`timescale 1ns/10ps
interface dp_bus_if;
   import dp_pkg::*;
   logic  bus_clk;
   logic  out_of_order_notice;
   logic  data_input_power_ctl;
   link_t cpu_o;
   link_t cpu_oe;
   link_t cs_o;
   link_t cs_oe;
   link_t link;

   // Pulled-up wired bus: undriven lines rest at the idle high level
   assign link = (cpu_o | ~cpu_oe) & (cs_o | ~cs_oe);

   modport cpu (
      input  bus_clk,
      input  out_of_order_notice,
      input  data_input_power_ctl,
      input  link,
      output cpu_o,
      output cpu_oe
   );
   modport cs (
      output bus_clk,
      output out_of_order_notice,
      output data_input_power_ctl,
      output cs_o,
      output cs_oe,
      input  link
   );
endinterface

// *** cpu_data_end.sv ***
`timescale 1ns/10ps
`include "dp_defs.svh"
// Functional notes
// - 64-bit data path, lines wired pin to pin
// - Four data beats per bus clock
// - Capture on falling edge of either strobe
// - Four 16-bit groups, own strobes and flag
// - Active flag means group is inverted
// - Invert when over half bits would toggle; beat 0 counts bits differing from all-high
// - Flag travels and latches with group strobes
// - Data valid asserted in every data clock
// - Idle clocks drop valid; receiver ignores data
// - Busy held while driving; release frees bus
// - Target signals deferral; processor takes it in
// - Chipset control lowers processor input power
// - Both agents time off bus clock
// - Same bus clock frequency at both agents
module data_phase_engine #(
   parameter int DEPTH     = `DP_BUF_DEPTH,
   parameter int HALF      = `DP_HALF_CYC,
   parameter int BURST_MAX = `DP_BURST_MAX,
   parameter bit SLOT      = `DP_SLOT_CPU
) (
   input  wire logic          ref_clk,
   input  wire logic          nrst,
   input  wire logic          link_rise,
   input  wire logic          rx_power_low,
   input  wire logic          tx_valid,
   output logic               tx_ready,
   input  wire dp_pkg::word_t tx_data,
   output logic               rx_valid,
   output dp_pkg::word_t      rx_data,
   output logic               engine_busy,
   output dp_pkg::link_t      link_o,
   output dp_pkg::link_t      link_oe,
   input  wire dp_pkg::link_t link_i
);
   import dp_pkg::*;

   localparam int G        = `DP_GROUPS;
   localparam int GW       = `DP_GRP_W;
   localparam int BEATS    = `DP_BEATS;
   localparam int PERIOD   = 2 * HALF;
   localparam int BEAT_CYC = PERIOD / BEATS;
   localparam int STB_AT   = BEAT_CYC / 2;
   localparam int CW       = $clog2(PERIOD);
   localparam int PW       = $clog2(DEPTH);
   localparam int BW       = $clog2(BEATS);
   localparam int FW       = BW + 1;
   localparam int LW       = $clog2(BURST_MAX + 1);

   word_t         buf_q   [DEPTH];
   word_t         buf_d   [DEPTH];
   word_t         stage_q [BEATS];
   word_t         stage_d [BEATS];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] wr_d;
   logic [PW-1:0] rd_q;
   logic [PW-1:0] rd_d;
   logic [PW:0]   cnt_q;
   logic [PW:0]   cnt_d;
   logic [FW-1:0] fill_q;
   logic [FW-1:0] fill_d;
   tx_st_t        st_q;
   tx_st_t        st_d;
   logic [CW-1:0] cyc_q;
   logic [CW-1:0] cyc_d;
   logic [LW-1:0] lines_q;
   logic [LW-1:0] lines_d;
   logic          par_q;
   logic          par_d;
   link_t         out_q;
   link_t         out_d;
   link_t         s1_q;
   link_t         s2_q;
   logic [G-1:0]  pos_q;
   logic [G-1:0]  neg_q;
   word_t         grp_q;
   word_t         grp_d;
   logic [G-1:0]  got_q;
   logic [G-1:0]  got_d;
   word_t         rxd_q;
   word_t         rxd_d;
   logic          rxv_q;
   logic          rxv_d;
   logic          full;
   logic          push;
   logic          pop;
   logic          start;
   logic          cap_en;
   logic [BW-1:0] beat;
   logic [CW-1:0] sub;
   word_t         data_in;
   logic [G-1:0]  flag_in;

   function automatic logic [PW-1:0] inc_ptr(input logic [PW-1:0] p);
      inc_ptr = (p == PW'(DEPTH - 1)) ? '0 : p + 1'h1;
   endfunction

   // Source stalls here only while the buffer holds DEPTH words
   assign full        = (cnt_q == (PW + 1)'(DEPTH));
   assign tx_ready    = !full;
   assign push        = tx_valid && !full;
   assign pop         = (cnt_q != '0) && (fill_q != FW'(BEATS))
                        && (st_q != ST_SEND);
   assign start       = link_rise && (fill_q == FW'(BEATS));
   assign engine_busy = (st_q != ST_IDLE) || (fill_q != '0)
                        || (cnt_q != '0);
   assign beat        = BW'(cyc_q / CW'(BEAT_CYC));
   assign sub         = cyc_q % CW'(BEAT_CYC);

   always_comb begin
      buf_d   = buf_q;
      stage_d = stage_q;
      wr_d    = wr_q;
      rd_d    = rd_q;
      if (push) begin
         buf_d[wr_q] = tx_data;
         wr_d        = inc_ptr(wr_q);
      end
      if (pop) begin
         stage_d[fill_q[BW-1:0]] = buf_q[rd_q];
         rd_d                    = inc_ptr(rd_q);
      end
      cnt_d = cnt_q + (PW + 1)'(push) - (PW + 1)'(pop);
   end

   // Fixed slot parity keeps the two agents from claiming together
   always_comb begin
      st_d    = st_q;
      cyc_d   = cyc_q;
      lines_d = lines_q;
      par_d   = link_rise ? !par_q : par_q;
      fill_d  = pop ? fill_q + 1'h1 : fill_q;
      unique case (st_q)
         ST_IDLE: begin
            if (start && par_q == SLOT && s2_q.busy != `DP_ACT) begin
               st_d    = ST_SEND;
               cyc_d   = '0;
               lines_d = LW'(1);
            end
         end
         ST_SEND: begin
            if (cyc_q == CW'(PERIOD - 1)) begin
               st_d   = ST_HOLD;
               fill_d = '0;
            end else begin
               cyc_d = cyc_q + 1'h1;
            end
         end
         ST_HOLD: begin
            if (link_rise) begin
               if (start && lines_q != LW'(BURST_MAX)) begin
                  st_d    = ST_SEND;
                  cyc_d   = '0;
                  lines_d = lines_q + 1'h1;
               end else begin
                  st_d = ST_IDLE;
               end
            end
         end
         default: st_d = ST_IDLE;
      endcase
   end

   always_comb begin
      out_d = out_q;
      if (st_q == ST_IDLE) begin
         out_d = '1;
      end else begin
         out_d.busy  = `DP_ACT;
         out_d.valid = (st_q == ST_SEND) ? `DP_ACT : `DP_IDLE;
         if (st_q == ST_HOLD) begin
            out_d.pos = '1;
            out_d.neg = '1;
         end
         if (st_q == ST_SEND && sub == '0) begin
            for (int g = 0; g < G; g++) begin
               {out_d.flag[g], out_d.data[g*GW +: GW]} =
                  bus_encode((beat == '0) ? '1 : out_q.data[g*GW +: GW],
                             stage_q[beat][g*GW +: GW]);
            end
         end
         if (st_q == ST_SEND && sub == CW'(STB_AT)) begin
            out_d.pos = {G{beat[0] ^ `DP_ACT}};
            out_d.neg = {G{~(beat[0] ^ `DP_ACT)}};
         end
      end
   end

   assign link_o  = out_q;
   assign link_oe = {$bits(link_t){st_q != ST_IDLE}};

   // Input buffers off: receiver sees only the resting level
   assign data_in = rx_power_low ? '1 : s2_q.data;
   assign flag_in = rx_power_low ? '1 : s2_q.flag;
   assign cap_en  = (s2_q.valid == `DP_ACT) && (st_q == ST_IDLE);

   always_comb begin
      grp_d = grp_q;
      got_d = got_q;
      rxd_d = rxd_q;
      rxv_d = 1'h0;
      if (!cap_en) begin
         got_d = '0;
      end
      for (int g = 0; g < G; g++) begin
         if (cap_en && ((pos_q[g] && !s2_q.pos[g])
                        || (neg_q[g] && !s2_q.neg[g]))) begin
            grp_d[g*GW +: GW] = bus_decode(flag_in[g],
                                           data_in[g*GW +: GW]);
            got_d[g] = 1'h1;
         end
      end
      if (&got_d) begin
         rxv_d = 1'h1;
         rxd_d = grp_d;
         got_d = '0;
      end
   end

   assign rx_valid = rxv_q;
   assign rx_data  = rxd_q;

   // Payload storage carries no reset; control below does
   always_ff @(posedge ref_clk) begin
      buf_q   <= buf_d;
      stage_q <= stage_d;
      grp_q   <= grp_d;
      rxd_q   <= rxd_d;
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wr_q    <= '0;
         rd_q    <= '0;
         cnt_q   <= '0;
         fill_q  <= '0;
         st_q    <= ST_IDLE;
         cyc_q   <= '0;
         lines_q <= '0;
         par_q   <= 1'h0;
         out_q   <= '1;
         s1_q    <= '1;
         s2_q    <= '1;
         pos_q   <= '1;
         neg_q   <= '1;
         got_q   <= '0;
         rxv_q   <= 1'h0;
      end else begin
         wr_q    <= wr_d;
         rd_q    <= rd_d;
         cnt_q   <= cnt_d;
         fill_q  <= fill_d;
         st_q    <= st_d;
         cyc_q   <= cyc_d;
         lines_q <= lines_d;
         par_q   <= par_d;
         out_q   <= out_d;
         s1_q    <= link_i;
         s2_q    <= s1_q;
         pos_q   <= s2_q.pos;
         neg_q   <= s2_q.neg;
         got_q   <= got_d;
         rxv_q   <= rxv_d;
      end
   end
endmodule

module cpu_data_end #(
   parameter int DEPTH     = `DP_BUF_DEPTH,
   parameter int HALF      = `DP_HALF_CYC,
   parameter int BURST_MAX = `DP_BURST_MAX
) (
   input  wire logic          ref_clk,
   input  wire logic          nrst,
   dp_bus_if.cpu              bus,
   input  wire logic          tx_valid,
   output logic               tx_ready,
   input  wire dp_pkg::word_t tx_data,
   output logic               rx_valid,
   output dp_pkg::word_t      rx_data,
   output logic               out_of_order_notice_seen,
   output logic               input_power_low
);
   import dp_pkg::*;

   logic clk_s1_q;
   logic clk_s2_q;
   logic clk_s3_q;
   logic dfr_s1_q;
   logic dfr_s2_q;
   logic pwr_s1_q;
   logic pwr_s2_q;
   logic out_of_order_notice_q;
   logic out_of_order_notice_d;
   logic plow_q;
   logic plow_d;
   logic link_rise;

   // Bus clock is sampled, so only its rising edges steer timing
   assign link_rise = clk_s2_q && !clk_s3_q;
   assign out_of_order_notice_d   = (dfr_s2_q == `DP_ACT);
   assign plow_d    = (pwr_s2_q == `DP_ACT);

   assign out_of_order_notice_seen      = out_of_order_notice_q;
   assign input_power_low = plow_q;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         clk_s1_q <= 1'h0;
         clk_s2_q <= 1'h0;
         clk_s3_q <= 1'h0;
         dfr_s1_q <= `DP_IDLE;
         dfr_s2_q <= `DP_IDLE;
         pwr_s1_q <= `DP_IDLE;
         pwr_s2_q <= `DP_IDLE;
         out_of_order_notice_q  <= 1'h0;
         plow_q   <= 1'h0;
      end else begin
         clk_s1_q <= bus.bus_clk;
         clk_s2_q <= clk_s1_q;
         clk_s3_q <= clk_s2_q;
         dfr_s1_q <= bus.out_of_order_notice;
         dfr_s2_q <= dfr_s1_q;
         pwr_s1_q <= bus.data_input_power_ctl;
         pwr_s2_q <= pwr_s1_q;
         out_of_order_notice_q  <= out_of_order_notice_d;
         plow_q   <= plow_d;
      end
   end

   data_phase_engine #(
      .DEPTH     (DEPTH),
      .HALF      (HALF),
      .BURST_MAX (BURST_MAX),
      .SLOT      (`DP_SLOT_CPU)
   ) u_engine (
      .ref_clk      (ref_clk),
      .nrst         (nrst),
      .link_rise    (link_rise),
      .rx_power_low (plow_q),
      .tx_valid     (tx_valid),
      .tx_ready     (tx_ready),
      .tx_data      (tx_data),
      .rx_valid     (rx_valid),
      .rx_data      (rx_data),
      .engine_busy  (),
      .link_o       (bus.cpu_o),
      .link_oe      (bus.cpu_oe),
      .link_i       (bus.link)
   );
endmodule

// *** cs_data_end.sv ***
`timescale 1ns/10ps
`include "dp_defs.svh"
module cs_data_end #(
   parameter int DEPTH     = `DP_BUF_DEPTH,
   parameter int HALF      = `DP_HALF_CYC,
   parameter int BURST_MAX = `DP_BURST_MAX
) (
   input  wire logic          ref_clk,
   input  wire logic          nrst,
   dp_bus_if.cs               bus,
   input  wire logic          tx_valid,
   output logic               tx_ready,
   input  wire dp_pkg::word_t tx_data,
   output logic               rx_valid,
   output dp_pkg::word_t      rx_data,
   input  wire logic          out_of_order_notice_req,
   input  wire logic          pwr_save_req
);
   import dp_pkg::*;

   localparam int DW = (HALF > 1) ? $clog2(HALF) : 1;

   logic [DW-1:0] div_q;
   logic [DW-1:0] div_d;
   logic          bclk_q;
   logic          bclk_d;
   logic          dfr_q;
   logic          dfr_d;
   logic          pwr_q;
   logic          pwr_d;
   logic          wrap;
   logic          link_rise;
   logic          busy;

   // This end makes the bus clock for both agents
   assign wrap      = (div_q == DW'(HALF - 1));
   assign link_rise = wrap && !bclk_q;

   always_comb begin
      div_d  = wrap ? '0 : div_q + 1'h1;
      bclk_d = wrap ? !bclk_q : bclk_q;
      dfr_d  = out_of_order_notice_req ? `DP_ACT : `DP_IDLE;
      // Power stays up from first queued word until the bus is let go
      pwr_d  = (pwr_save_req && !busy) ? `DP_ACT : `DP_IDLE;
   end

   assign bus.bus_clk              = bclk_q;
   assign bus.out_of_order_notice  = dfr_q;
   assign bus.data_input_power_ctl = pwr_q;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         div_q  <= '0;
         bclk_q <= 1'h0;
         dfr_q  <= `DP_IDLE;
         pwr_q  <= `DP_IDLE;
      end else begin
         div_q  <= div_d;
         bclk_q <= bclk_d;
         dfr_q  <= dfr_d;
         pwr_q  <= pwr_d;
      end
   end

   data_phase_engine #(
      .DEPTH     (DEPTH),
      .HALF      (HALF),
      .BURST_MAX (BURST_MAX),
      .SLOT      (`DP_SLOT_CS)
   ) u_engine (
      .ref_clk      (ref_clk),
      .nrst         (nrst),
      .link_rise    (link_rise),
      .rx_power_low (1'h0),
      .tx_valid     (tx_valid),
      .tx_ready     (tx_ready),
      .tx_data      (tx_data),
      .rx_valid     (rx_valid),
      .rx_data      (rx_data),
      .engine_busy  (busy),
      .link_o       (bus.cs_o),
      .link_oe      (bus.cs_oe),
      .link_i       (bus.link)
   );
endmodule

// *** dp_properties.sv ***
`timescale 1ns/10ps
module dp_properties (
   input wire logic          ref_clk,
   input wire logic          nrst,
   input wire logic          bus_clk,
   input wire dp_pkg::link_t cpu_oe,
   input wire dp_pkg::link_t cs_oe,
   input wire dp_pkg::link_t link
);
   import dp_pkg::*;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   // Coding keeps every group at eight wire flips or fewer per beat, save beat 0 of a line sent straight after a held line
   function automatic bit few_flips(input logic [63:0] a,
                                    input logic [63:0] b);
      few_flips = 1'h1;
      for (int g = 0; g < 4; g++) begin
         if ($countones(a[16*g +: 16] ^ b[16*g +: 16]) > 8) begin
            few_flips = 1'h0;
         end
      end
   endfunction

   a_valid_eight_low: assert property (
      $fell(link.valid) |-> (!link.valid)[*8] ##1 link.valid)
      else $error("data valid not low for exactly one bus clock");
   a_busy_covers_valid: assert property (
      !link.valid |-> !link.busy)
      else $error("valid data without bus busy");
   a_strobe_pair_excl: assert property (
      ((~link.pos) & (~link.neg)) == 4'h0)
      else $error("both strobes of a pair low together");
   a_strobe_in_valid: assert property (
      ((link.pos & link.neg) != 4'hF) |-> !link.valid)
      else $error("strobe fell outside a valid clock");
   a_flip_limit: assert property (
      (!link.valid && !$past(link.valid))
      |-> few_flips(link.data, $past(link.data)))
      else $error("group changed more than half its lines");
   // Only the falling edge latches; a strobe stays low into the next beat
   a_beat_stable_strobe: assert property (
      (|(($past(link.pos) & ~link.pos) | ($past(link.neg) & ~link.neg)))
      |-> ($stable(link.data) && $stable(link.flag)))
      else $error("data or flag moved at its strobe");
   a_quad_beats: assert property (
      $fell(link.valid) |-> ##1 (link.pos == 4'h0 && link.neg == 4'hF)
      ##2 (link.pos == 4'hF && link.neg == 4'h0)
      ##2 (link.pos == 4'h0 && link.neg == 4'hF)
      ##2 (link.pos == 4'hF && link.neg == 4'h0))
      else $error("strobe beats out of order");
   a_bus_clk_half: assert property (
      $rose(bus_clk) |-> bus_clk[*4] ##1 !bus_clk)
      else $error("bus clock high phase not four cycles");
   a_one_owner: assert property (
      !(cpu_oe.busy && cs_oe.busy))
      else $error("both ends drive bus busy");
endmodule

// *** testbench.sv ***
`timescale 1ns/10ps
module testbench;
   import dp_pkg::*;
   logic        ref_clk;
   logic        nrst;
   logic [1:0]  txv;
   word_t       txd [2];
   wire [1:0]   rdy;
   wire [1:0]   rxv;
   wire word_t  rxd [2];
   wire         out_of_order_notice_seen;
   wire         input_power_low;
   logic        out_of_order_notice_req;
   logic        pwr_save_req;
   logic        saw_full;
   word_t       got [2][$];
   word_t       pat [8];
   int          bad_count;
   int          checks_done;

   dp_bus_if dp_bus_if_inst ();
   cpu_data_end cpu_data_end_inst (.ref_clk(ref_clk), .nrst(nrst),
      .bus(dp_bus_if_inst), .tx_valid(txv[0]), .tx_ready(rdy[0]),
      .tx_data(txd[0]), .rx_valid(rxv[0]), .rx_data(rxd[0]),
      .out_of_order_notice_seen(out_of_order_notice_seen), .input_power_low(input_power_low));
   cs_data_end cs_data_end_inst (.ref_clk(ref_clk), .nrst(nrst),
      .bus(dp_bus_if_inst), .tx_valid(txv[1]), .tx_ready(rdy[1]),
      .tx_data(txd[1]), .rx_valid(rxv[1]), .rx_data(rxd[1]),
      .out_of_order_notice_req(out_of_order_notice_req), .pwr_save_req(pwr_save_req));
   dp_properties dp_properties_inst (.ref_clk(ref_clk), .nrst(nrst),
      .bus_clk(dp_bus_if_inst.bus_clk), .cpu_oe(dp_bus_if_inst.cpu_oe),
      .cs_oe(dp_bus_if_inst.cs_oe), .link(dp_bus_if_inst.link));

   initial begin
      ref_clk = 1'h0;
      forever #25 ref_clk = ~ref_clk;
   end

   // Pre-edge sampling: registered outputs settle after the edge
   always @(posedge ref_clk) begin
      for (int e = 0; e < 2; e++) begin
         if (rxv[e] === 1'h1) got[e].push_back(rxd[e]);
      end
      if (rdy[0] === 1'h0) saw_full = 1'h1;
   end

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Valid stays up between words; data held until ready seen
   task automatic send(input int e, input int n, input word_t salt);
      int guard;
      @(posedge ref_clk);
      #1;
      txv[e] = 1'h1;
      for (int k = 0; k < n; k++) begin
         txd[e] = pat[k % 8] ^ salt;
         guard = 0;
         @(negedge ref_clk);
         while (rdy[e] !== 1'h1 && guard < 2000) begin
            @(negedge ref_clk);
            guard++;
         end
         @(posedge ref_clk);
         #1;
      end
      txv[e] = 1'h0;
   endtask

   task automatic expect_rx(input int e, input int n, input word_t salt);
      int guard;
      guard = 0;
      while (got[e].size() < n && guard < 3000) begin
         @(posedge ref_clk);
         #1;
         guard++;
      end
      check(64'(got[e].size()), 64'(n));
      for (int k = 0; k < n && k < got[e].size(); k++) begin
         check(got[e][k], pat[k % 8] ^ salt);
      end
      got[e].delete();
   endtask

   task automatic reset_state;
      check(64'({rdy, rxv}), 64'hC);
      check(64'({out_of_order_notice_seen, input_power_low}), 64'h0);
      check(dp_bus_if_inst.link.data, 64'hFFFFFFFFFFFFFFFF);
      check(64'({dp_bus_if_inst.link.flag, dp_bus_if_inst.link.pos,
         dp_bus_if_inst.link.neg, dp_bus_if_inst.link.valid,
         dp_bus_if_inst.link.busy}), 64'h3FFF);
      check(64'({dp_bus_if_inst.out_of_order_notice,
         dp_bus_if_inst.data_input_power_ctl}), 64'h3);
   endtask

   task automatic one_way(input int e, input word_t salt);
      send(e, 4, salt);
      expect_rx(1 - e, 4, salt);
      check(64'(got[e].size()), 64'h0);
   endtask

   // More lines than one ownership allows, so the bus is handed back
   task automatic burst_fill;
      saw_full = 1'h0;
      send(0, 20, 64'h1111111111111111);
      expect_rx(1, 20, 64'h1111111111111111);
      check(64'(saw_full), 64'h1);
   endtask

   task automatic both_ways;
      fork
         send(0, 8, 64'h3333333333333333);
         send(1, 8, 64'h00FF00FF00FF00FF);
      join
      expect_rx(1, 8, 64'h3333333333333333);
      expect_rx(0, 8, 64'h00FF00FF00FF00FF);
   endtask

   task automatic out_of_order_notice_chk;
      out_of_order_notice_req = 1'h1;
      repeat (3) @(posedge ref_clk);
      #1;
      check(64'(out_of_order_notice_seen), 64'h0);
      check(64'(dp_bus_if_inst.out_of_order_notice), 64'h0);
      @(posedge ref_clk);
      #1;
      check(64'(out_of_order_notice_seen), 64'h1);
      out_of_order_notice_req = 1'h0;
   endtask

   // Chipset lifts power control itself as soon as it queues words
   task automatic power_chk;
      pwr_save_req = 1'h1;
      for (int i = 0; i < 20 && input_power_low !== 1'h1; i++) begin
         @(posedge ref_clk);
         #1;
      end
      check(64'(input_power_low), 64'h1);
      check(64'(dp_bus_if_inst.data_input_power_ctl), 64'h0);
      one_way(1, 64'h0F0F0F0F0F0F0F0F);
      pwr_save_req = 1'h0;
      for (int i = 0; i < 20 && input_power_low !== 1'h0; i++) begin
         @(posedge ref_clk);
         #1;
      end
      check(64'(input_power_low), 64'h0);
   endtask

   initial begin
      nrst = 1'h0;
      txv = 2'h0;
      txd[0] = 64'h0;
      txd[1] = 64'h0;
      out_of_order_notice_req = 1'h0;
      pwr_save_req = 1'h0;
      saw_full = 1'h0;
      bad_count = 0;
      checks_done = 0;
      pat = '{64'h0, 64'hFFFFFFFFFFFFFFFF, 64'h00FF00FF00FF00FF,
         64'hAAAA5555AAAA5555, 64'h0123456789ABCDEF,
         64'hFFFF0000FFFF0000, 64'h8000000100FF7FFE,
         64'hFEDCBA9876543210};
      repeat (12) @(posedge ref_clk);
      #1;
      nrst = 1'h1;
      reset_state();
      one_way(0, 64'h0);
      one_way(1, 64'h5A5A5A5A5A5A5A5A);
      burst_fill();
      both_ways();
      out_of_order_notice_chk();
      power_chk();
      end_sim();
   end

   // Whole run needs a few hundred cycles; allow ample margin
   initial begin
      #1000000;
      bad_count++;
      $display("ERROR at %0t: run did not finish", $time);
      end_sim();
   end
endmodule
